// ### logic/mfdt_regs.vh
// Register offsets, field positions, reset values and timing counts of the multifunction block
`ifndef MFDT_REGS_VH
`define MFDT_REGS_VH
`define MFDT_ADR_PORT_OUT 8'h00
`define MFDT_ADR_PORT_IN 8'h04
`define MFDT_ADR_LOCAL_RD 8'h08
`define MFDT_ADR_SCAN 8'h0C
`define MFDT_ADR_TOT_CTRL 8'h10
`define MFDT_ADR_TOT_COUNT 8'h14
`define MFDT_ADR_DAC1 8'h18
`define MFDT_ADR_DAC2 8'h1C
`define MFDT_ADR_SCAN_RD 8'h20
`define MFDT_ADR_STATUS 8'h24
`define MFDT_TOT_FALL_BIT 0
`define MFDT_TOT_CLEAR_BIT 1
`define MFDT_SCAN_P1_BIT 0
`define MFDT_SCAN_P2_BIT 1
`define MFDT_SCAN_ACT_BIT 2
`define MFDT_LOCAL_SEL_BIT 0
`define MFDT_PORT_OUT_RST 16'hFFFF
`define MFDT_DAC_RST 16'h8000
`define MFDT_CTRL_RST 2'h0
`define MFDT_SCAN_RST 3'h0
`define MFDT_TOT_MAX 26'h3FFFFFF
`define MFDT_UNMAPPED_DATA 32'h00000000
`define MFDT_CLK_HZ 200000000
`define MFDT_PULSE_MAX_HZ 100000
`define MFDT_PULSE_MIN_CYC (`MFDT_CLK_HZ / `MFDT_PULSE_MAX_HZ)
`endif

// ### logic/mfdt_sync2.v
// Two flip-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module mfdt_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ### logic/mfdt_top.v
// Digital ports, gated pulse totalizer and analog output codes behind a Wishbone slave
`timescale 1ns/1ps
`include "mfdt_regs.vh"

// How it works
// RULE1: Two 8-bit ports, each sampled in and driven out through open-drain pins.
// RULE2: Remote port read returns both ports as 16 bits unless either is scanned.
// RULE3: Local read returns only the one selected 8-bit port per access.
// RULE4: The totalizer is a 26-bit counter reaching 67,108,863.
// RULE5: Every qualifying pulse up to 100 kHz is counted, none missed.
// RULE6: A control bit selects rising or falling counting edge.
// RULE7: True-sense gate enables counting high, disables low.
// RULE8: Inverted-sense gate enables counting low, disables high.
// RULE9: Counting happens only while both gates are enabling.
// RULE10: Port inputs and count can be read as scan measurements during a scan.
// RULE11: Each of two analog channels holds a 16-bit output code.
// RULE12: Pulse and gate pins pass a two-stage synchroniser before edge detection.
// RULE13: An increment from the maximum count wraps to zero.
module mfdt_top #(
    parameter PORT_W = 8,
    parameter COUNT_W = 26,
    parameter DAC_W = 16
) (
    // Clock and reset
    input wire clk_in,
    input wire arst_n_in,
    // Wishbone slave
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output wire wb_ack_out,
    // Digital port pins, open drain
    input wire [PORT_W-1:0] port1_pin_in,
    output wire [PORT_W-1:0] port1_pin_out,
    output wire [PORT_W-1:0] port1_pin_oe_n_out,
    input wire [PORT_W-1:0] port2_pin_in,
    output wire [PORT_W-1:0] port2_pin_out,
    output wire [PORT_W-1:0] port2_pin_oe_n_out,
    // Totalizer pins
    input wire tot_pulse_in,
    input wire tot_gate_in,
    input wire tot_gate_n_in,
    // Analog output codes
    output wire [DAC_W-1:0] dac1_code_out,
    output wire [DAC_W-1:0] dac2_code_out
);
    localparam CW = COUNT_W;

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for register writes
    function [31:0] lane_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] sel;
        integer i;
        begin
            lane_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    // Zero extension of the port pair to a bus word
    function [31:0] zext_port;
        input [2*PORT_W-1:0] val;
        begin
            zext_port = {{(32-2*PORT_W){1'b0}}, val};
        end
    endfunction

    // Zero extension of a count to a bus word
    function [31:0] zext_count;
        input [CW-1:0] val;
        begin
            zext_count = {{(32-CW){1'b0}}, val};
        end
    endfunction

    // Zero extension of an output code to a bus word
    function [31:0] zext_dac;
        input [DAC_W-1:0] val;
        begin
            zext_dac = {{(32-DAC_W){1'b0}}, val};
        end
    endfunction

    // One selected port out of the pair
    function [PORT_W-1:0] local_byte;
        input sel;
        input [2*PORT_W-1:0] ports;
        begin
            local_byte = sel ? ports[2*PORT_W-1:PORT_W] : ports[PORT_W-1:0];
        end
    endfunction

    // Both gates in their enabling state
    function gate_open;
        input gate;
        input gate_n;
        begin
            gate_open = gate && !gate_n;
        end
    endfunction

    // Counting edge chosen by the edge control bit
    function edge_pick;
        input fall_mode;
        input rise;
        input fall;
        begin
            edge_pick = fall_mode ? fall : rise;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    wire [2*PORT_W-1:0] ports_sync;
    wire [2:0] tot_sync;

    mfdt_sync2 #(.WIDTH(2*PORT_W)) u_port_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in({port2_pin_in, port1_pin_in}),
        .sync_out(ports_sync)
    );

    mfdt_sync2 #(.WIDTH(3)) u_tot_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in({tot_gate_n_in, tot_gate_in, tot_pulse_in}),
        .sync_out(tot_sync)
    ); // RULE12

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [2*PORT_W-1:0] port_out_ff;
    reg [1:0] tot_ctrl_ff;
    reg [2:0] scan_ff;
    reg local_sel_ff;
    reg [DAC_W-1:0] dac1_ff;
    reg [DAC_W-1:0] dac2_ff;
    reg [CW-1:0] count_ff;
    reg pulse_prev_ff;
    reg wrapped_ff;
    reg ack_ff;
    reg [2*PORT_W-1:0] scan_ports_ff;
    reg [CW-1:0] scan_count_ff;

    wire req = wb_cyc_in && wb_stb_in && !ack_ff;
    wire wr = req && wb_we_in;
    wire [31:0] wdat_port = lane_merge(zext_port(port_out_ff), wb_dat_in, wb_sel_in);
    wire [31:0] wdat_ctrl = lane_merge({30'h0, tot_ctrl_ff}, wb_dat_in, wb_sel_in);
    wire [31:0] wdat_scan = lane_merge({29'h0, scan_ff}, wb_dat_in, wb_sel_in);
    wire [31:0] wdat_sel = lane_merge({31'h0, local_sel_ff}, wb_dat_in, wb_sel_in);
    wire [31:0] wdat_dac1 = lane_merge(zext_dac(dac1_ff), wb_dat_in, wb_sel_in);
    wire [31:0] wdat_dac2 = lane_merge(zext_dac(dac2_ff), wb_dat_in, wb_sel_in);
    wire clear_cmd = wr && (wb_adr_in == `MFDT_ADR_TOT_CTRL) &&
        wdat_ctrl[`MFDT_TOT_CLEAR_BIT];

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            port_out_ff <= `MFDT_PORT_OUT_RST;
            tot_ctrl_ff <= `MFDT_CTRL_RST;
            scan_ff <= `MFDT_SCAN_RST;
            local_sel_ff <= 1'b0;
            dac1_ff <= `MFDT_DAC_RST;
            dac2_ff <= `MFDT_DAC_RST;
        end else if (wr) begin
            case (wb_adr_in)
                `MFDT_ADR_PORT_OUT: begin
                    port_out_ff <= wdat_port[2*PORT_W-1:0]; // RULE1
                end
                `MFDT_ADR_TOT_CTRL: begin
                    tot_ctrl_ff <= {1'b0, wdat_ctrl[`MFDT_TOT_FALL_BIT]}; // RULE6
                end
                `MFDT_ADR_SCAN: begin
                    scan_ff <= wdat_scan[2:0];
                end
                `MFDT_ADR_LOCAL_RD: begin
                    local_sel_ff <= wdat_sel[`MFDT_LOCAL_SEL_BIT];
                end
                `MFDT_ADR_DAC1: begin
                    dac1_ff <= wdat_dac1[DAC_W-1:0]; // RULE11
                end
                `MFDT_ADR_DAC2: begin
                    dac2_ff <= wdat_dac2[DAC_W-1:0]; // RULE11
                end
                default: begin
                    port_out_ff <= port_out_ff;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Totalizer
    wire pulse_s = tot_sync[0];
    wire gate_ok = gate_open(tot_sync[1], tot_sync[2]); // RULE7 RULE8 RULE9
    wire edge_rise = pulse_s && !pulse_prev_ff;
    wire edge_fall = !pulse_s && pulse_prev_ff;
    wire edge_hit = edge_pick(tot_ctrl_ff[`MFDT_TOT_FALL_BIT], edge_rise, edge_fall); // RULE6
    wire count_en = edge_hit && gate_ok; // RULE9
    wire at_max = (count_ff == `MFDT_TOT_MAX);
    reg [CW-1:0] nxt_count;

    always @* begin
        nxt_count = count_ff;
        if (count_en) begin
            nxt_count = at_max ? {CW{1'b0}} : count_ff + 1'b1; // RULE4 RULE13
        end else if (clear_cmd) begin
            nxt_count = {CW{1'b0}};
        end
    end

    // Every synchronised edge is seen once per clock; 100 kHz is far below
    // the clock, so no edge is missed
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pulse_prev_ff <= 1'b0;
            count_ff <= {CW{1'b0}};
            wrapped_ff <= 1'b0;
        end else begin
            pulse_prev_ff <= pulse_s; // RULE12
            count_ff <= nxt_count; // RULE5
            if (count_en && at_max) begin
                wrapped_ff <= 1'b1; // RULE13
            end else if (clear_cmd) begin
                wrapped_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan snapshot
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            scan_ports_ff <= {(2*PORT_W){1'b0}};
            scan_count_ff <= {CW{1'b0}};
        end else if (scan_ff[`MFDT_SCAN_ACT_BIT]) begin
            scan_ports_ff <= ports_sync; // RULE10
            scan_count_ff <= count_ff; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge
    wire scan_busy = scan_ff[`MFDT_SCAN_P1_BIT] || scan_ff[`MFDT_SCAN_P2_BIT];
    reg [31:0] nxt_rdat;

    always @* begin
        case (wb_adr_in)
            `MFDT_ADR_PORT_OUT: begin
                nxt_rdat = zext_port(port_out_ff);
            end
            `MFDT_ADR_PORT_IN: begin
                nxt_rdat = scan_busy ? 32'h00000000 : zext_port(ports_sync); // RULE2
            end
            `MFDT_ADR_LOCAL_RD: begin
                nxt_rdat = {{(32-PORT_W){1'b0}}, local_byte(local_sel_ff, ports_sync)}; // RULE3
            end
            `MFDT_ADR_SCAN: begin
                nxt_rdat = {29'h0, scan_ff};
            end
            `MFDT_ADR_TOT_CTRL: begin
                nxt_rdat = {30'h0, tot_ctrl_ff};
            end
            `MFDT_ADR_TOT_COUNT: begin
                nxt_rdat = zext_count(count_ff); // RULE4
            end
            `MFDT_ADR_DAC1: begin
                nxt_rdat = zext_dac(dac1_ff);
            end
            `MFDT_ADR_DAC2: begin
                nxt_rdat = zext_dac(dac2_ff);
            end
            `MFDT_ADR_SCAN_RD: begin
                nxt_rdat = zext_count(scan_count_ff); // RULE10
            end
            `MFDT_ADR_STATUS: begin
                nxt_rdat = {{(32-2*PORT_W-2){1'b0}}, wrapped_ff, scan_busy,
                    scan_ports_ff}; // RULE10
            end
            default: begin
                nxt_rdat = `MFDT_UNMAPPED_DATA;
            end
        endcase
    end

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_ff <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            ack_ff <= req;
            if (req && !wb_we_in) begin
                wb_dat_out <= nxt_rdat;
            end
        end
    end

    assign wb_ack_out = ack_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: a 0 bit pulls the open-drain pin low
    assign port1_pin_out = {PORT_W{1'b0}};
    assign port2_pin_out = {PORT_W{1'b0}};
    assign port1_pin_oe_n_out = port_out_ff[PORT_W-1:0]; // RULE1
    assign port2_pin_oe_n_out = port_out_ff[2*PORT_W-1:PORT_W]; // RULE1
    assign dac1_code_out = dac1_ff;
    assign dac2_code_out = dac2_ff;
endmodule

// ### tb/mfdt_top_sva.sv
// Checker for the port, totalizer and code block
`timescale 1ns/1ps
module mfdt_top_sva #(
    parameter PORT_W = 8,
    parameter DAC_W = 16
) (
    // Clock, reset and bus
    input wire clk_in,
    input wire arst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    // Pins and codes
    input wire [PORT_W-1:0] port1_pin_out,
    input wire [PORT_W-1:0] port1_pin_oe_n_out,
    input wire [PORT_W-1:0] port2_pin_out,
    input wire [DAC_W-1:0] dac1_code_out,
    input wire [DAC_W-1:0] dac2_code_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire rq = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire wr = rq && wb_we_in && wb_sel_in == 4'hF;
    wire rd = rq && !wb_we_in;
    a_ack_next: assert property (rq |=> wb_ack_out) else $error("no ack");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
    a_pins_sink: assert property (~|{port1_pin_out, port2_pin_out}) else $error("pin high");
    a_port_drive: assert property (wr && wb_adr_in == 8'h00 |=>
        port1_pin_oe_n_out == $past(wb_dat_in[7:0])) else $error("port out");
    a_dac1_load: assert property (wr && wb_adr_in == 8'h18 |=>
        dac1_code_out == $past(wb_dat_in[15:0])) else $error("code 1");
    a_dac2_load: assert property (wr && wb_adr_in == 8'h1C |=>
        dac2_code_out == $past(wb_dat_in[15:0])) else $error("code 2");
    a_dac_hold: assert property (!(rq && wb_we_in) |=>
        $stable({dac1_code_out, dac2_code_out})) else $error("code moved");
    a_port_word: assert property (rd && wb_adr_in == 8'h04 |=>
        wb_dat_out[31:16] == 16'h0) else $error("port word");
    a_local_byte: assert property (rd && wb_adr_in == 8'h08 |=>
        wb_dat_out[31:8] == 24'h0) else $error("local byte");
    a_count_width: assert property (rd && wb_adr_in == 8'h14 |=>
        wb_dat_out[31:26] == 6'h0) else $error("count width");
    cover property (wr && wb_adr_in == 8'h18);
    cover property (rd && wb_adr_in == 8'h14);
    cover property (rd && wb_adr_in == 8'h20);
endmodule
bind mfdt_top mfdt_top_sva #(.PORT_W(PORT_W), .DAC_W(DAC_W)) mfdt_top_sva_inst (.*);

// ### tb/mfdt_partner.sv
// Far side: pulse source and pulled-up open-drain pin loads
`timescale 1ns/1ps
module mfdt_partner (
    input wire clk_in,
    input wire [15:0] oe_n_in,
    input wire [15:0] ext_in,
    output wire [15:0] pin_out,
    output reg pulse_out
);
    // Line follows its source unless the block sinks it
    assign pin_out = ext_in & oe_n_in;
    initial pulse_out = 1'b0;
    // Each pulse high and low for w clocks, then the count settles
    task pulses(input int n, input int w);
        repeat (n) begin
            pulse_out <= 1'b1;
            repeat (w) @(posedge clk_in);
            pulse_out <= 1'b0;
            repeat (w) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ### tb/tb_mfdt_top.sv
// Self-checking bench for the port, totalizer and code block
`timescale 1ns/1ps
module tb_mfdt_top;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic gate = 1'b1;
    logic gate_n = 1'b0;
    logic [15:0] ext = 16'hFFFF;
    wire [31:0] rdat;
    wire ack;
    wire [7:0] o1, o2;
    wire [15:0] pins;
    wire pulse;
    int failures = 0;
    int checks = 0;
    integer seed = 32'hc23d5088;
    logic [31:0] exp_q[$];
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] ov = 16'hFFFF;
    logic [15:0] lv;
    mfdt_top mfdt_top_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .port1_pin_in(pins[7:0]), .port1_pin_out(), .port1_pin_oe_n_out(o1),
        .port2_pin_in(pins[15:8]), .port2_pin_out(), .port2_pin_oe_n_out(o2),
        .tot_pulse_in(pulse), .tot_gate_in(gate), .tot_gate_n_in(gate_n),
        .dac1_code_out(), .dac2_code_out());
    mfdt_partner mfdt_partner_inst (.clk_in(clk_in), .oe_n_in({o2, o1}), .ext_in(ext),
        .pin_out(pins), .pulse_out(pulse));
    initial forever #2.5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////
    task results;
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [3:0] sl, input logic [31:0] v);
        int n;
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, sl, v};
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            failures++;
            results;
        end
        {cyc, stb} <= 2'b00;
        @(posedge clk_in);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 4'hF, 32'h0);
    endtask
    task compare(input logic [31:0] e);
        checks++;
        if (rdat !== e) begin
            failures++;
            $display("CHECK FAILED %0t read %h expected %h", $time, rdat, e);
        end
    endtask
    // Oldest noted read against each answer
    always @(posedge clk_in) begin
        if (ack === 1'b1 && we === 1'b0) begin
            compare(exp_q.size() > 0 ? exp_q.pop_front() : ~rdat);
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        rd(8'h00, 32'h0000FFFF);
        rd(8'h18, 32'h00008000);
        rd(8'h1C, 32'h00008000);
        rd(8'h14, 32'h0);
        rd(8'h28, 32'h0);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            s = $random(seed);
            bus(1'b1, 8'h00, s, d);
            if (s[0]) ov[7:0] = d[7:0];
            if (s[1]) ov[15:8] = d[15:8];
            ext <= $random(seed);
            repeat (4) @(posedge clk_in);
            rd(8'h04, {16'h0, ext & ov});
            rd(8'h00, {16'h0, ov});
            bus(1'b1, 8'h08, 4'hF, i % 2);
            lv = (ext & ov) >> (8 * (i % 2));
            rd(8'h08, {24'h0, lv[7:0]});
            bus(1'b1, i % 2 ? 8'h1C : 8'h18, 4'hF, d);
            rd(i % 2 ? 8'h1C : 8'h18, {16'h0, d[15:0]});
        end
        mfdt_partner_inst.pulses(5, 2);
        rd(8'h14, 32'd5);
        bus(1'b1, 8'h0C, 4'hF, 32'h5);
        rd(8'h04, 32'h0);
        mfdt_partner_inst.pulses(2, 2);
        rd(8'h20, 32'd7);
        bus(1'b1, 8'h0C, 4'hF, 32'h2);
        rd(8'h04, 32'h0);
        mfdt_partner_inst.pulses(1, 2);
        rd(8'h20, 32'd7);
        rd(8'h24, {14'h0, 1'b0, 1'b1, ext & ov});
        rd(8'h14, 32'd8);
        mfdt_partner_inst.pulse_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd(8'h14, 32'd9);
        bus(1'b1, 8'h10, 4'hF, 32'h1);
        rd(8'h10, 32'h1);
        mfdt_partner_inst.pulse_out <= 1'b0;
        repeat (6) @(posedge clk_in);
        rd(8'h14, 32'd10);
        for (int g = 0; g < 4; g++) begin
            {gate_n, gate} <= g[1:0] ^ 2'b01;
            @(posedge clk_in);
            mfdt_partner_inst.pulses(3, 2);
            rd(8'h14, 32'd13);
        end
        bus(1'b1, 8'h10, 4'hF, 32'h2);
        rd(8'h14, 32'h0);
        results;
    end
endmodule
